/* hdl/rom_map_pkg.sv */
// Behaviour
// - One optional 32Kx8 ROM, active-low chip select
// - ROM and redirection only when strap sampled
// - Bridge 2Ch-2Fh read from ROM 402Ch-402Fh
// - Bridge 60h-FFh read from ROM 4060h-40FFh
// - IDE 2Ch-2Fh read from ROM 412Ch-412Fh
// - Expansion ROM base plus offset reaches ROM
// - Base from expansion ROM register 30h
// - ROM cycles drive F0000h-F7FFFh only
// - Configuration writes never write the ROM
// - Config address bits 7:2 copied to ISA
// - Wide config reads split into byte reads
// - Memory space aliases configuration-mapped ROM bytes
// - Flash writes single byte, with voltage
// - Power line zero switches programming voltage
// - Feature bit 2 gates flash writes, strobe
// - Subsystem reads 00h unless 30h bit 0
package rom_map_pkg;

    // ****************************************
    // Configuration space map
    // ****************************************
    localparam logic [7:0]  FEATURE_CONTROL_OFS   = 8'h52;
    localparam logic [7:0]  FEATURE_CONTROL_RESET = 8'h20;
    localparam int          FC_FLASH_WR_BIT       = 2;
    localparam int          FC_IDE_EN_BIT         = 5;
    localparam logic [5:0]  XROM_BAR_WORD         = 6'h0C;
    localparam logic [31:0] XROM_BAR_WMASK        = 32'hFFFF_8001;
    localparam logic [31:0] XROM_BAR_RESET        = 32'h0000_0000;
    localparam int          XROM_EN_BIT           = 0;
    localparam logic [5:0]  SUBSYS_WORD           = 6'h0B;
    localparam logic [7:0]  CIS_FIRST_OFS         = 8'h60;

    // ****************************************
    // ROM placement on the ISA address bus
    // ****************************************
    localparam int          ROM_AW        = 15;
    localparam int          ISA_AW        = 20;
    localparam logic [19:0] ROM_SEG_BASE  = 20'hF0000;
    localparam logic [14:0] CFG_ROM_BASE  = 15'h4000;

    // ****************************************
    // ROM cycle timing
    // ****************************************
    localparam int ROM_ACCESS_NS = 150;
    localparam int CLK_PERIOD_NS = 50;
    localparam int ROM_CYCLES    = (ROM_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CNT_W         = 4;

    typedef struct packed {
        logic        cfg;
        logic        ide_fn;
        logic        write;
        logic [31:0] addr;
        logic [3:0]  byte_en;
        logic [31:0] wdata;
    } host_req_s;

    typedef struct packed {
        logic        cs_n;
        logic        rd_n;
        logic        wr_n;
        logic [19:0] addr;
        logic [7:0]  data;
        logic        data_oe_n;
    } rom_bus_s;

    typedef enum logic [1:0] {
        MAP_IDLE,
        MAP_LANE,
        MAP_WAIT,
        MAP_FINISH
    } map_state_e;

    typedef enum logic [1:0] {
        CYC_IDLE,
        CYC_STROBE,
        CYC_RECOVER
    } cyc_state_e;

endpackage

/* hdl/rom_byte_cycle.sv */
`timescale 1ns/1ps
`default_nettype none
module rom_byte_cycle
    import rom_map_pkg::*;
(
    input  wire logic              i_clk_sys,
    input  wire logic              i_reset_n,
    input  wire logic              i_start,
    input  wire logic              i_write,
    input  wire logic [ISA_AW-1:0] i_addr,
    input  wire logic [7:0]        i_wdata,
    input  wire logic [7:0]        i_rom_data,
    output var  rom_bus_s          o_bus,
    output logic                   o_done,
    output logic [7:0]             o_rdata
);

    cyc_state_e             state_q;
    logic [CNT_W-1:0]       cnt_q;
    logic                   last_w;

    assign last_w = (cnt_q == CNT_W'(ROM_CYCLES - 1));

    // ****************************************
    // One byte: strobe held for the access time, then a recovery cycle
    // ****************************************
    always_ff @(posedge i_clk_sys) begin
        if (!i_reset_n) begin
            state_q <= CYC_IDLE;
            cnt_q   <= '0;
            o_done  <= 1'b0;
            o_rdata <= 8'h00;
            o_bus   <= '{cs_n: 1'b1, rd_n: 1'b1, wr_n: 1'b1, addr: ROM_SEG_BASE,
                         data: 8'h00, data_oe_n: 1'b1};
        end else begin
            o_done <= 1'b0;
            unique case (state_q)
                CYC_IDLE: begin
                    if (i_start) begin
                        state_q         <= CYC_STROBE;
                        cnt_q           <= '0;
                        o_bus.addr      <= i_addr;
                        o_bus.cs_n      <= 1'b0;
                        o_bus.rd_n      <= i_write;
                        o_bus.wr_n      <= !i_write;
                        o_bus.data      <= i_wdata;
                        o_bus.data_oe_n <= !i_write;
                    end
                end
                CYC_STROBE: begin
                    cnt_q <= cnt_q + CNT_W'(1);
                    if (last_w) begin
                        state_q    <= CYC_RECOVER;
                        o_rdata    <= i_rom_data;
                        o_bus.cs_n <= 1'b1;
                        o_bus.rd_n <= 1'b1;
                        o_bus.wr_n <= 1'b1;
                    end
                end
                CYC_RECOVER: begin
                    // Data stays driven one cycle past the write strobe for hold time
                    state_q         <= CYC_IDLE;
                    o_bus.data_oe_n <= 1'b1;
                    o_done          <= 1'b1;
                end
            endcase
        end
    end

endmodule
`default_nettype wire

/* hdl/option_rom_config_mapper.sv */
`timescale 1ns/1ps
`default_nettype none
module option_rom_config_mapper
    import rom_map_pkg::*;
(
    input  wire logic        i_clk_sys,
    input  wire logic        i_reset_n,
    input  wire logic        i_rom_strap,
    input  wire logic        i_req_valid,
    input  wire host_req_s   i_req,
    output logic             o_req_ready,
    output logic             o_done,
    output logic             o_claimed,
    output logic [31:0]      o_rdata,
    input  wire logic        i_latched_power_line_zero,
    input  wire logic        i_low_mem_write_n,
    output logic             o_low_memory_write_strobe_n,
    output logic             o_rom_chip_select_n,
    output logic             o_rom_read_n,
    output logic             o_rom_write_n,
    output logic [19:0]      o_isa_addr,
    output logic [7:0]       o_isa_data,
    output logic             o_isa_data_oe_n,
    input  wire logic [7:0]  i_isa_data,
    output logic [7:0]       o_feature_control
);

    // ****************************************
    // State
    // ****************************************
    map_state_e       state_q;
    host_req_s        req_q;
    logic [3:0]       lanes_q;
    logic [31:0]      rdata_q;
    logic             claimed_q;
    logic             done_q;
    logic             strap_q;
    logic [7:0]       feature_q;
    logic [31:0]      bar_q [2];

    // ****************************************
    // Lane decode
    // ****************************************
    logic [1:0]       ln;
    logic             lanes_empty;
    logic [31:0]      bar_sel;
    logic             bar_en;
    logic [7:0]       cfg_ofs;
    logic             subsys_hit;
    logic             cis_hit;
    logic             cfg_redir;
    logic             mem_hit0;
    logic             mem_hit1;
    logic             mem_hit;
    logic             single_byte;
    logic             flash_wr_ok;
    logic             rom_op;
    logic [14:0]      rom_off;
    logic [19:0]      rom_addr;
    logic [7:0]       lane_wdata;
    logic [7:0]       reg_byte;
    logic             start_eng;
    rom_bus_s         eng_bus;
    logic             eng_done;
    logic [7:0]       eng_rdata;

    function automatic logic [1:0] low_lane(input logic [3:0] m);
        logic [1:0] r;
        r = 2'd3;
        if (m[2]) r = 2'd2;
        if (m[1]) r = 2'd1;
        if (m[0]) r = 2'd0;
        return r;
    endfunction

    assign ln          = low_lane(lanes_q);
    assign lanes_empty = (lanes_q == 4'h0);
    assign cfg_ofs     = {req_q.addr[7:2], ln};
    assign bar_sel     = bar_q[req_q.ide_fn];
    assign bar_en      = bar_sel[XROM_EN_BIT];
    assign lane_wdata  = req_q.wdata[8*ln +: 8];

    assign subsys_hit  = req_q.cfg && (req_q.addr[7:2] == SUBSYS_WORD) && strap_q;
    assign cis_hit     = req_q.cfg && !req_q.ide_fn && (cfg_ofs >= CIS_FIRST_OFS) && strap_q;
    // Subsystem bytes only come from the ROM once that function's ROM is enabled
    assign cfg_redir   = !req_q.write && ((subsys_hit && bar_en) || cis_hit);

    assign mem_hit0    = bar_q[0][XROM_EN_BIT]
                         && (req_q.addr[31:ROM_AW] == bar_q[0][31:ROM_AW]);
    assign mem_hit1    = bar_q[1][XROM_EN_BIT] && feature_q[FC_IDE_EN_BIT]
                         && (req_q.addr[31:ROM_AW] == bar_q[1][31:ROM_AW]);
    assign mem_hit     = !req_q.cfg && strap_q && (mem_hit0 || mem_hit1);

    assign single_byte = (req_q.byte_en != 4'h0)
                         && ((req_q.byte_en & (req_q.byte_en - 4'h1)) == 4'h0);
    assign flash_wr_ok = single_byte && feature_q[FC_FLASH_WR_BIT]
                         && i_latched_power_line_zero;
    // Config writes never reach the ROM, even to redirected bytes
    assign rom_op      = cfg_redir || (mem_hit && (!req_q.write || flash_wr_ok));

    // Config path keeps address bits 7:2 and adds the function select at bit 8
    assign rom_off     = req_q.cfg ? (CFG_ROM_BASE | {6'h00, req_q.ide_fn, cfg_ofs})
                                   : {req_q.addr[14:2], ln};
    assign rom_addr    = ROM_SEG_BASE | {5'h00, rom_off};

    always_comb begin
        reg_byte = 8'h00;
        if (req_q.cfg && (req_q.addr[7:2] == XROM_BAR_WORD)) begin
            reg_byte = bar_sel[8*ln +: 8];
        end else if (req_q.cfg && !req_q.ide_fn && (cfg_ofs == FEATURE_CONTROL_OFS)) begin
            reg_byte = feature_q;
        end
    end

    assign start_eng = (state_q == MAP_LANE) && !lanes_empty && rom_op;

    rom_byte_cycle u_cycle (
        .i_clk_sys  (i_clk_sys),
        .i_reset_n  (i_reset_n),
        .i_start    (start_eng),
        .i_write    (req_q.write),
        .i_addr     (rom_addr),
        .i_wdata    (lane_wdata),
        .i_rom_data (i_isa_data),
        .o_bus      (eng_bus),
        .o_done     (eng_done),
        .o_rdata    (eng_rdata)
    );

    // ****************************************
    // Strap capture during reset
    // ****************************************
    always_ff @(posedge i_clk_sys) begin
        if (!i_reset_n) begin
            strap_q <= i_rom_strap;
        end
    end

    // ****************************************
    // Byte lane sequencer
    // ****************************************
    always_ff @(posedge i_clk_sys) begin
        if (!i_reset_n) begin
            state_q   <= MAP_IDLE;
            req_q     <= '0;
            lanes_q   <= 4'h0;
            rdata_q   <= 32'h0000_0000;
            claimed_q <= 1'b0;
            done_q    <= 1'b0;
        end else begin
            done_q <= 1'b0;
            unique case (state_q)
                MAP_IDLE: begin
                    if (i_req_valid) begin
                        state_q <= MAP_LANE;
                        req_q   <= i_req;
                        lanes_q <= i_req.byte_en;
                        rdata_q <= 32'h0000_0000;
                    end
                end
                MAP_LANE: begin
                    if (lanes_empty) begin
                        state_q   <= MAP_FINISH;
                        claimed_q <= req_q.cfg || mem_hit;
                    end else if (rom_op) begin
                        state_q <= MAP_WAIT;
                    end else begin
                        rdata_q[8*ln +: 8] <= req_q.write ? 8'h00 : reg_byte;
                        lanes_q[ln]        <= 1'b0;
                    end
                end
                MAP_WAIT: begin
                    // Host sits in wait states until each ROM byte is back
                    if (eng_done) begin
                        state_q            <= MAP_LANE;
                        rdata_q[8*ln +: 8] <= req_q.write ? 8'h00 : eng_rdata;
                        lanes_q[ln]        <= 1'b0;
                    end
                end
                MAP_FINISH: begin
                    state_q <= MAP_IDLE;
                    done_q  <= 1'b1;
                end
            endcase
        end
    end

    // ****************************************
    // Configuration registers
    // ****************************************
    logic reg_wr;
    assign reg_wr = (state_q == MAP_LANE) && !lanes_empty && req_q.cfg && req_q.write;

    always_ff @(posedge i_clk_sys) begin
        if (!i_reset_n) begin
            feature_q <= FEATURE_CONTROL_RESET;
            bar_q[0]  <= XROM_BAR_RESET;
            bar_q[1]  <= XROM_BAR_RESET;
        end else if (reg_wr) begin
            if (!req_q.ide_fn && (cfg_ofs == FEATURE_CONTROL_OFS)) begin
                feature_q <= lane_wdata;
            end
            if (req_q.addr[7:2] == XROM_BAR_WORD) begin
                bar_q[req_q.ide_fn][8*ln +: 8] <= lane_wdata & XROM_BAR_WMASK[8*ln +: 8];
            end
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    assign o_req_ready         = (state_q == MAP_IDLE);
    assign o_done              = done_q;
    assign o_claimed           = claimed_q;
    assign o_rdata             = rdata_q;
    assign o_feature_control   = feature_q;
    // Chip select is absent entirely without the strap
    assign o_rom_chip_select_n = eng_bus.cs_n || !strap_q;
    assign o_rom_read_n        = eng_bus.rd_n;
    assign o_rom_write_n       = eng_bus.wr_n;
    assign o_isa_addr          = eng_bus.addr;
    assign o_isa_data          = eng_bus.data;
    assign o_isa_data_oe_n     = eng_bus.data_oe_n;
    assign o_low_memory_write_strobe_n = i_low_mem_write_n
                                         || !feature_q[FC_FLASH_WR_BIT];

endmodule
`default_nettype wire

/* verification/rom_model.sv */
`timescale 1ns/1ps
`default_nettype none
module rom_model (
    input  wire logic        i_clk_sys,
    input  wire logic        i_cs_n,
    input  wire logic        i_rd_n,
    input  wire logic        i_wr_n,
    input  wire logic [19:0] i_addr,
    input  wire logic [7:0]  i_data,
    input  wire logic        i_oe_n,
    input  wire logic        i_vpp,
    output logic [7:0]       o_data
);
    logic [7:0] mem [0:32767];
    logic [7:0] last_q;
    wire  logic rd = !i_cs_n && !i_rd_n;
    initial begin
        for (int i = 0; i < 32768; i++) mem[i] = 8'(i[7:0] ^ i[14:8] ^ 8'h5A);
        last_q = 8'h00;
    end
    // Released bus toggles so a sample one cycle late sees the old byte inverted
    assign o_data = rd ? mem[i_addr[14:0]] : ~last_q;
    always @(posedge i_clk_sys) begin
        last_q <= rd ? mem[i_addr[14:0]] : ~last_q;
        if (!i_cs_n && !i_wr_n && !i_oe_n && i_vpp) mem[i_addr[14:0]] <= i_data;
    end
endmodule
`default_nettype wire

/* verification/option_rom_config_mapper_chk.sv */
`timescale 1ns/1ps
`default_nettype none
module option_rom_config_mapper_chk
    import rom_map_pkg::*;
(
    input wire logic        i_clk_sys,
    input wire logic        i_reset_n,
    input wire logic        i_rom_strap,
    input wire logic        i_req_valid,
    input wire host_req_s   i_req,
    input wire logic        o_req_ready,
    input wire logic        o_done,
    input wire logic        i_latched_power_line_zero,
    input wire logic        i_low_mem_write_n,
    input wire logic        o_low_memory_write_strobe_n,
    input wire logic        o_rom_chip_select_n,
    input wire logic        o_rom_read_n,
    input wire logic        o_rom_write_n,
    input wire logic [19:0] o_isa_addr,
    input wire logic        o_isa_data_oe_n,
    input wire logic [7:0]  o_feature_control
);
    logic      strap_q;
    host_req_s req_q;
    wire logic take = i_req_valid && o_req_ready;
    wire logic cs_n = o_rom_chip_select_n;
    always_ff @(posedge i_clk_sys) begin
        if (!i_reset_n) strap_q <= i_rom_strap;
        if (take) req_q <= i_req;
    end
    default clocking @(posedge i_clk_sys); endclocking
    default disable iff (!i_reset_n);
    property p_range; !cs_n |-> o_isa_addr[19:15] == 5'h1E; endproperty
    a_range: assert property (p_range) else $error("rom select outside segment");
    property p_no_strap; !strap_q |-> cs_n; endproperty
    a_no_strap: assert property (p_no_strap) else $error("rom select without strap");
    property p_strobe; $fell(cs_n) |-> (!cs_n && !(o_rom_read_n && o_rom_write_n))[*3] ##1 cs_n;
    endproperty
    a_strobe: assert property (p_strobe) else $error("rom strobe length wrong");
    property p_wr_gate; $fell(o_rom_write_n) |->
        o_feature_control[2] && i_latched_power_line_zero && !o_isa_data_oe_n; endproperty
    a_wr_gate: assert property (p_wr_gate) else $error("flash write not gated");
    property p_low; o_low_memory_write_strobe_n == (i_low_mem_write_n | !o_feature_control[2]);
    endproperty
    a_low: assert property (p_low) else $error("low write strobe not blocked");
    property p_cfg_wr; take && i_req.cfg && i_req.write |=> o_rom_write_n[*4]; endproperty
    a_cfg_wr: assert property (p_cfg_wr) else $error("config write reached rom");
    property p_busy; take |=> !o_req_ready; endproperty
    a_busy: assert property (p_busy) else $error("ready while busy");
    property p_done; o_done |=> o_req_ready && !o_done; endproperty
    a_done: assert property (p_done) else $error("done not single pulse");
    property p_cfg_addr; $fell(cs_n) && req_q.cfg |->
        o_isa_addr[19:2] == {5'h1E, 6'h20, req_q.ide_fn, req_q.addr[7:2]}; endproperty
    a_cfg_addr: assert property (p_cfg_addr) else $error("config rom address");
    // Each lane opens its own strobe, so the low two bits follow the lane, not the request
    property p_mem_addr; $fell(cs_n) && !req_q.cfg |-> o_isa_addr[14:2] == req_q.addr[14:2];
    endproperty
    a_mem_addr: assert property (p_mem_addr) else $error("memory rom address");
endmodule
bind option_rom_config_mapper option_rom_config_mapper_chk u_chk (.i_clk_sys, .i_reset_n,
    .i_rom_strap, .i_req_valid, .i_req, .o_req_ready, .o_done, .i_latched_power_line_zero,
    .i_low_mem_write_n, .o_low_memory_write_strobe_n, .o_rom_chip_select_n, .o_rom_read_n,
    .o_rom_write_n, .o_isa_addr, .o_isa_data_oe_n, .o_feature_control);
`default_nettype wire

/* verification/option_rom_config_mapper_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module option_rom_config_mapper_tb;
    import rom_map_pkg::*;
    logic clk, rst_n, strap, valid, vpp, lmw_n, ready, done, claimed, lms_n;
    logic cs_n, rd_n, wr_n, oe_n;
    logic [31:0] rdata;
    logic [19:0] isa_addr;
    logic [7:0]  isa_wd, isa_rd, feat;
    host_req_s   req_v;
    int          mismatches, checks_done;
    option_rom_config_mapper DUT (.i_clk_sys(clk), .i_reset_n(rst_n), .i_rom_strap(strap),
        .i_req_valid(valid), .i_req(req_v), .o_req_ready(ready), .o_done(done),
        .o_claimed(claimed), .o_rdata(rdata), .i_latched_power_line_zero(vpp),
        .i_low_mem_write_n(lmw_n), .o_low_memory_write_strobe_n(lms_n),
        .o_rom_chip_select_n(cs_n), .o_rom_read_n(rd_n), .o_rom_write_n(wr_n),
        .o_isa_addr(isa_addr), .o_isa_data(isa_wd), .o_isa_data_oe_n(oe_n),
        .i_isa_data(isa_rd), .o_feature_control(feat));
    rom_model u_rom (.i_clk_sys(clk), .i_cs_n(cs_n), .i_rd_n(rd_n), .i_wr_n(wr_n),
        .i_addr(isa_addr), .i_data(isa_wd), .i_oe_n(oe_n), .i_vpp(vpp), .o_data(isa_rd));
    // ****************************************
    // Helpers
    // ****************************************
    function automatic logic [7:0] romv(input logic [14:0] a);
        return a[7:0] ^ {1'b0, a[14:8]} ^ 8'h5A;
    endfunction
    function automatic logic [31:0] rom4(input logic [14:0] a);
        return {romv(a + 15'h3), romv(a + 15'h2), romv(a + 15'h1), romv(a)};
    endfunction
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic rst(input logic s);
        @(negedge clk);
        rst_n = 1'b0;
        strap = s;
        repeat (20) @(negedge clk);
        rst_n = 1'b1;
    endtask
    // One request; the design is idle here so the first edge takes it
    task automatic req(input logic c, f, w, input logic [31:0] a, input logic [3:0] be,
                       input logic [31:0] d);
        int n;
        n = 0;
        @(negedge clk);
        valid = 1'b1;
        req_v = '{c, f, w, a, be, d};
        @(negedge clk);
        valid = 1'b0;
        while (done !== 1'b1 && n < 100) begin
            @(negedge clk);
            n++;
        end
        chk("done seen", 32'h1, {31'h0, done});
    endtask
    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_regs();
        chk("feature reset", 32'h20, {24'h0, feat});
        chk("rdata reset", 32'h0, rdata);
        req(1, 0, 1, 32'h50, 4'h4, 32'h0024_0000);
        chk("feature write", 32'h24, {24'h0, feat});
        $display("regs done");
    endtask
    task automatic t_cfg();
        req(1, 0, 0, 32'h2C, 4'hF, '0);
        chk("subsys off", 32'h0, rdata);
        req(1, 0, 1, 32'h30, 4'hF, 32'h1000_0001);
        req(1, 0, 0, 32'h2C, 4'hF, '0);
        chk("subsys fn0", rom4(15'h402C), rdata);
        req(1, 1, 1, 32'h30, 4'hF, 32'h2000_0001);
        req(1, 1, 0, 32'h2C, 4'hC, '0);
        chk("subsys fn1", rom4(15'h412C) & 32'hFFFF_0000, rdata);
        req(1, 0, 0, 32'h60, 4'h1, '0);
        chk("cis first", {24'h0, romv(15'h4060)}, rdata);
        req(1, 0, 0, 32'hFC, 4'hF, '0);
        chk("cis last", rom4(15'h40FC), rdata);
        req(1, 0, 1, 32'h2C, 4'hF, 32'hDEAD_BEEF);
        req(1, 0, 0, 32'h2C, 4'hF, '0);
        chk("cfg read only", rom4(15'h402C), rdata);
        $display("cfg done");
    endtask
    task automatic t_mem();
        req(0, 0, 0, 32'h1000_402C, 4'hF, '0);
        chk("mem alias", rom4(15'h402C), rdata);
        chk("mem claim", 32'h1, {31'h0, claimed});
        req(0, 0, 0, 32'h1000_7FFC, 4'hF, '0);
        chk("mem top", rom4(15'h7FFC), rdata);
        req(0, 0, 0, 32'h2000_0010, 4'h1, '0);
        chk("mem fn1", {24'h0, romv(15'h0010)}, rdata);
        req(0, 0, 0, 32'h3000_0000, 4'h1, '0);
        chk("mem miss", 32'h0, {31'h0, claimed});
        $display("mem done");
    endtask
    task automatic t_flash();
        vpp = 1'b1;
        req(0, 0, 1, 32'h1000_0100, 4'h1, 32'h0000_00A5);
        req(0, 0, 0, 32'h1000_0100, 4'h1, '0);
        chk("flash write", 32'hA5, rdata);
        vpp = 1'b0;
        req(0, 0, 1, 32'h1000_0100, 4'h1, 32'h0000_005A);
        vpp = 1'b1;
        req(0, 0, 1, 32'h1000_0100, 4'h3, 32'h0000_3C3C);
        lmw_n = 1'b0;
        req(1, 0, 1, 32'h50, 4'h4, 32'h0020_0000);
        chk("strobe blocked", 32'h1, {31'h0, lms_n});
        req(0, 0, 1, 32'h1000_0100, 4'h1, 32'h0000_00C3);
        req(0, 0, 0, 32'h1000_0100, 4'h1, '0);
        chk("flash kept", 32'hA5, rdata);
        lmw_n = 1'b1;
        $display("flash done");
    endtask
    task automatic t_strap();
        rst(1'b0);
        req(1, 0, 1, 32'h30, 4'hF, 32'h1000_0001);
        req(1, 0, 0, 32'h2C, 4'hF, '0);
        chk("no strap cfg", 32'h0, rdata);
        req(0, 0, 0, 32'h1000_402C, 4'hF, '0);
        chk("no strap mem", 32'h0, {31'h0, claimed});
        $display("strap done");
    endtask
    // ****************************************
    // Run
    // ****************************************
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    initial begin
        repeat (4000) @(posedge clk);
        mismatches++;
        wrap_up();
    end
    initial begin
        {rst_n, valid, vpp} = 3'h0;
        {strap, lmw_n} = 2'h3;
        req_v = '0;
        rst(1'b1);
        t_regs();
        t_cfg();
        t_mem();
        t_flash();
        t_strap();
        wrap_up();
    end
endmodule
`default_nettype wire
